// file: logic/srlc_pkg.sv
// Package of the serial receive link control block.
// Assumes a single core clock at 40 MHz and APB register access.
package srlc_pkg;

  localparam int          ADDR_W          = 12;
  localparam logic [11:0] OFS_CTRL        = 12'h000;
  localparam logic [11:0] OFS_STATUS      = 12'h004;
  localparam logic [11:0] OFS_IRQ_STAT    = 12'h008;
  localparam logic [11:0] OFS_IRQ_EN      = 12'h00C;
  localparam logic [11:0] OFS_IRQ_CLR     = 12'h010;
  localparam logic [11:0] OFS_FRAME       = 12'h014;

  // Control register fields
  localparam int CTRL_WIDE     = 0;
  localparam int CTRL_TEST_CLOCK_IN_SEL = 1;
  localparam int CTRL_SW_RST   = 2;

  // Interrupt event bits
  localparam int IRQ_W          = 3;
  localparam int EV_LINK_UP     = 0;
  localparam int EV_LINK_DOWN   = 1;
  localparam int EV_FRAME_ERR   = 2;

  localparam int DATA_W_WIDE   = 20;
  localparam int DATA_W_NARROW = 16;

  // Frame clock divider and start-up dwell
  localparam int FRAME_DIV_DEF  = 4;
  localparam int FILL_DWELL_DEF = 8;
  localparam int CORE_CLK_MHZ   = 40;

  // Start-up states; bit0 drives tx_startup_ctrl_a / freq_detect_disable,
  // bit1 drives the fill control / link-active line
  typedef enum logic [1:0] {
    SRLC_ST_FILL0  = 2'b00,
    SRLC_ST_FILL1  = 2'b01,
    SRLC_ST_SYNC   = 2'b10,
    SRLC_ST_ACTIVE = 2'b11
  } srlc_state_e;

  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

endpackage : srlc_pkg

// file: logic/srlc_sync2.sv
// Two flip-flop synchroniser for a bus of asynchronous levels.
// Assumes the destination clock is core_clk.
`timescale 1ns/100ps
`default_nettype none
module srlc_sync2 #(
  parameter int          W        = 1,
  parameter logic [31:0] RST_VAL  = 32'h0000_0000
) (
  input  wire logic         core_clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_ff  <= RST_VAL[W-1:0];
      sync_out <= RST_VAL[W-1:0];
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule : srlc_sync2
`default_nettype wire

// file: logic/srlc_clkdiv.sv
// Frame-rate enable divider: one-cycle pulse every DIV clocks.
// Assumes a free running core_clk.
`timescale 1ns/100ps
`default_nettype none
module srlc_clkdiv #(
  parameter int DIV = 4
) (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic restart,
  output logic      tick
);
  localparam int CW = $clog2(DIV + 1);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_ff;

  always_ff @(posedge core_clk) begin
    if (srst || restart) begin
      cnt_ff <= '0;
      tick   <= 1'b0;
    end else begin
      tick   <= (cnt_ff == LAST);
      cnt_ff <= (cnt_ff == LAST) ? '0 : cnt_ff + 1'b1;
    end
  end
endmodule : srlc_clkdiv
`default_nettype wire

// file: logic/srlc_top.sv
// Control and status logic of a serial link receiver: width select,
// start-up state machine, state outputs, frame strobe, test clock select.
// Assumes pins are asynchronous to core_clk and APB runs on core_clk.
`timescale 1ns/100ps
`default_nettype none
module srlc_top
  import srlc_pkg::*;
#(
  parameter int FRAME_DIV  = FRAME_DIV_DEF,
  parameter int FILL_DWELL = FILL_DWELL_DEF
) (
  input  wire logic        core_clk,
  input  wire logic        srst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins
  input  wire logic        primary_fsm_reset_n,
  input  wire logic        lock_hold_reset_n,
  input  wire logic        wide_word_select,
  input  wire logic        test_clock_select,
  input  wire logic        test_clock_in,
  input  wire logic        link_active_in,
  input  wire logic [19:0] rx_word,
  input  wire logic        rx_data_valid_n,
  input  wire logic        rx_control_valid_n,
  input  wire logic        rx_error,
  input  wire logic        rx_fill_is_one,
  // Outputs
  output logic             fsm_state_bit0,
  output logic             fsm_state_bit1,
  output logic             recovered_frame_clock,
  output logic             freq_detect_disable,
  output logic             pll_restart,
  output logic             link_ready_n,
  output logic      [19:0] data_out,
  output logic             data_valid_n,
  output logic             control_valid_n,
  output logic             frame_error,
  output logic             fill_frame_status,
  output logic             irq
);

  // Synchronised pins
  logic [9:0] pin_s;
  srlc_sync2 #(.W(10), .RST_VAL(32'h0000_00C7)) u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .async_in ({rx_fill_is_one, rx_error, rx_control_valid_n, rx_data_valid_n,
                link_active_in, test_clock_in, test_clock_select, wide_word_select,
                lock_hold_reset_n, primary_fsm_reset_n}),
    .sync_out (pin_s)
  );
  wire rst0_n_s   = pin_s[0];
  wire rst1_n_s   = pin_s[1];
  wire wide_s     = pin_s[2];
  wire tsel_s     = pin_s[3];
  wire test_clock_in_s     = pin_s[4];
  wire active_s   = pin_s[5];
  wire dav_n_s    = pin_s[6];
  wire cav_n_s    = pin_s[7];
  wire err_s      = pin_s[8];
  wire fill1_s    = pin_s[9];

  logic [19:0] word_s1_ff;
  logic [19:0] word_s2_ff;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      word_s1_ff <= '0;
      word_s2_ff <= '0;
    end else begin
      word_s1_ff <= rx_word;
      word_s2_ff <= word_s1_ff;
    end
  end

  // Registers
  logic [31:0]      ctrl_ff;
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_en_ff;
  logic [15:0]      frame_cnt_ff;

  wire wide_mode  = wide_s | ctrl_ff[CTRL_WIDE];
  wire test_clock_in_mode  = tsel_s | ctrl_ff[CTRL_TEST_CLOCK_IN_SEL];
  wire fsm_rst    = ~rst0_n_s | ctrl_ff[CTRL_SW_RST];

  // Frame strobe: internal divider or the test clock
  logic vco_tick;
  logic test_clock_in_d_ff;
  srlc_clkdiv #(.DIV(FRAME_DIV)) u_div (
    .core_clk (core_clk),
    .srst     (srst),
    .restart  (fsm_rst),
    .tick     (vco_tick)
  );
  wire test_clock_in_rise  = test_clock_in_s & ~test_clock_in_d_ff;
  wire frame_tick = test_clock_in_mode ? test_clock_in_rise : vco_tick;

  // Start-up state machine
  srlc_state_e state_ff;
  srlc_state_e nxt_state;
  logic [7:0]  dwell_ff;
  localparam logic [7:0] DWELL_LAST = 8'(FILL_DWELL - 1);
  wire dwell_done = (dwell_ff == DWELL_LAST);
  wire hold_rst   = fsm_rst | ~rst1_n_s;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SRLC_ST_FILL0: begin
        if (frame_tick && dwell_done) begin
          nxt_state = SRLC_ST_FILL1;
        end
      end
      SRLC_ST_FILL1: begin
        if (frame_tick && dwell_done) begin
          nxt_state = SRLC_ST_SYNC;
        end
      end
      SRLC_ST_SYNC: begin
        if (frame_tick && dwell_done && !err_s) begin
          nxt_state = SRLC_ST_ACTIVE;
        end
      end
      SRLC_ST_ACTIVE: begin
        nxt_state = SRLC_ST_ACTIVE;
      end
      default: begin
        nxt_state = SRLC_ST_FILL0;
      end
    endcase
    if (hold_rst) begin
      nxt_state = SRLC_ST_FILL0;
    end
  end

  wire state_chg = (nxt_state != state_ff);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_ff  <= SRLC_ST_FILL0;
      dwell_ff  <= '0;
      test_clock_in_d_ff <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      test_clock_in_d_ff <= test_clock_in_s;
      if (state_chg || hold_rst) begin
        dwell_ff <= '0;
      end else if (frame_tick && !dwell_done) begin
        dwell_ff <= dwell_ff + 8'h01;
      end
    end
  end

  // Pin outputs and frame-retimed data
  wire [19:0] word_mask = wide_mode ? 20'hFFFFF : 20'h0FFFF;
  wire        is_fill   = dav_n_s & cav_n_s & ~err_s;
  wire        to_active = state_chg && (nxt_state == SRLC_ST_ACTIVE);
  wire        from_act  = state_chg && (state_ff == SRLC_ST_ACTIVE);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      fsm_state_bit0        <= 1'b0;
      fsm_state_bit1        <= 1'b0;
      freq_detect_disable   <= 1'b0;
      pll_restart           <= 1'b1;
      recovered_frame_clock <= 1'b0;
      link_ready_n          <= 1'b1;
      data_out              <= '0;
      data_valid_n          <= 1'b1;
      control_valid_n       <= 1'b1;
      frame_error           <= 1'b0;
      fill_frame_status     <= 1'b0;
    end else begin
      fsm_state_bit0        <= nxt_state[0];
      fsm_state_bit1        <= nxt_state[1];
      freq_detect_disable   <= nxt_state[0];
      pll_restart           <= hold_rst;
      recovered_frame_clock <= frame_tick;
      if (frame_tick) begin
        link_ready_n      <= ~active_s;
        data_out          <= word_s2_ff & word_mask;
        data_valid_n      <= dav_n_s;
        control_valid_n   <= cav_n_s;
        frame_error       <= err_s;
        fill_frame_status <= is_fill & fill1_s;
      end
    end
  end

  // APB slave, zero wait states
  wire acc      = psel & penable;
  wire wr       = acc & pwrite;
  wire hit_ctrl = (paddr == OFS_CTRL);
  wire hit_en   = (paddr == OFS_IRQ_EN);
  wire hit_clr  = (paddr == OFS_IRQ_CLR);
  wire mapped   = hit_ctrl | hit_en | hit_clr | (paddr == OFS_STATUS)
                | (paddr == OFS_IRQ_STAT) | (paddr == OFS_FRAME);

  logic [IRQ_W-1:0] ev;
  always_comb begin
    ev               = '0;
    ev[EV_LINK_UP]   = to_active;
    ev[EV_LINK_DOWN] = from_act;
    ev[EV_FRAME_ERR] = frame_tick & err_s;
  end

  wire [IRQ_W-1:0] clr_bits = (wr && hit_clr) ? pwdata[IRQ_W-1:0] : '0;

  logic [31:0] rd_mux;
  always_comb begin
    case (paddr)
      OFS_CTRL:     rd_mux = ctrl_ff;
      OFS_STATUS:   rd_mux = {24'h000000, 1'b0, link_ready_n, wide_mode, test_clock_in_mode,
                              rst1_n_s, rst0_n_s, state_ff};
      OFS_IRQ_STAT: rd_mux = {29'h00000000, irq_stat_ff};
      OFS_IRQ_EN:   rd_mux = {29'h00000000, irq_en_ff};
      OFS_FRAME:    rd_mux = {16'h0000, frame_cnt_ff};
      default:      rd_mux = RD_ZERO;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_ff      <= '0;
      irq_en_ff    <= '0;
      irq_stat_ff  <= '0;
      frame_cnt_ff <= '0;
      prdata       <= '0;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      irq          <= 1'b0;
    end else begin
      if (wr && hit_ctrl) begin
        ctrl_ff <= {29'h00000000, pwdata[2:0]};
      end
      if (wr && hit_en) begin
        irq_en_ff <= pwdata[IRQ_W-1:0];
      end
      irq_stat_ff <= (irq_stat_ff & ~clr_bits) | ev;
      if (frame_tick) begin
        frame_cnt_ff <= frame_cnt_ff + 16'h0001;
      end
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel && !penable && !pwrite) ? rd_mux : prdata;
      irq     <= |(((irq_stat_ff & ~clr_bits) | ev) & irq_en_ff);
    end
  end

endmodule : srlc_top
`default_nettype wire

// file: verification/srlc_checker.sv
// Port checker of the receive link control block.
// Assumes it is bound to srlc_top.
`timescale 1ns/100ps
`default_nettype none
module srlc_checker (
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        primary_fsm_reset_n,
  input wire logic        lock_hold_reset_n,
  input wire logic        fsm_state_bit0,
  input wire logic        fsm_state_bit1,
  input wire logic        freq_detect_disable,
  input wire logic        pll_restart,
  input wire logic        recovered_frame_clock,
  input wire logic        link_ready_n,
  input wire logic [19:0] data_out,
  input wire logic        fill_frame_status
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  wire logic [1:0] st = {fsm_state_bit1, fsm_state_bit0};
  wire logic       fr = recovered_frame_clock;
  property p_rst; disable iff (1'b0) srst [*2] |=> st == 2'b00 && pll_restart; endproperty
  a_rst: assert property (p_rst) else $error("state kept in reset");
  property p_hold0; !primary_fsm_reset_n [*6] |-> st == 2'b00 && pll_restart; endproperty
  a_hold0: assert property (p_hold0) else $error("primary reset ignored");
  property p_hold1; !lock_hold_reset_n [*6] |-> st == 2'b00 && pll_restart; endproperty
  a_hold1: assert property (p_hold1) else $error("lock hold ignored");
  property p_step; $changed(st) |-> st == $past(st) + 2'd1 || st == 2'b00; endproperty
  a_step: assert property (p_step) else $error("state skipped");
  property p_dis; freq_detect_disable == fsm_state_bit0; endproperty
  a_dis: assert property (p_dis) else $error("detector disable off state");
  property p_pulse; fr |=> !fr; endproperty
  a_pulse: assert property (p_pulse) else $error("frame pulse too long");
  property p_ready; $changed(link_ready_n) |-> fr || $past(fr) || $past(fr, 2); endproperty
  a_ready: assert property (p_ready) else $error("ready off frame");
  property p_data; $changed({data_out, fill_frame_status}) |-> fr || $past(fr) || $past(fr, 2);
  endproperty
  a_data: assert property (p_data) else $error("data off frame");
endmodule : srlc_checker
`default_nettype wire

// file: verification/srlc_tx_model.sv
// Companion transmitter model: lock indication and link-active feed.
// Assumes the bench requests lock through lock_en.
`timescale 1ns/100ps
`default_nettype none
module srlc_tx_model #(
  parameter int LOCK_DLY = 6
) (
  input  wire logic core_clk,
  input  wire logic lock_en,
  input  wire logic fsm_state_bit1,
  output logic      tx_locked,
  output logic      link_active
);
  int cnt = 0;
  always @(posedge core_clk) begin
    cnt <= lock_en ? (cnt < LOCK_DLY ? cnt + 1 : cnt) : 0;
    tx_locked <= lock_en && cnt == LOCK_DLY;
  end
  assign link_active = fsm_state_bit1;
endmodule : srlc_tx_model
`default_nettype wire

// file: verification/srlc_top_bench.sv
// Self-checking bench of the receive link control block.
// Assumes the transmitter model drives lock and link-active.
`timescale 1ns/100ps
`default_nettype none
module srlc_top_bench;
  import srlc_pkg::*;
  logic        core_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'h361B4260;
  logic        primary_fsm_reset_n = 1'b1, wide_word_select = 1'b1, lock_en = 1'b0;
  logic        test_clock_select = 1'b0, test_clock_in = 1'b0;
  logic        rx_data_valid_n = 1'b1, rx_fill_is_one = 1'b0;
  logic        rx_control_valid_n = 1'b1, rx_error = 1'b0;
  logic [19:0] rx_word = 20'h00000, data_out;
  logic        lock_hold_reset_n, link_active_in, pready, pslverr, irq, pll_restart;
  logic        fsm_state_bit0, fsm_state_bit1, freq_detect_disable, recovered_frame_clock;
  logic        link_ready_n, data_valid_n, control_valid_n, frame_error, fill_frame_status;
  logic [32:0] rdq[$];
  logic [1:0]  stq[$], ps = 2'b00;
  int          errors = 0, num_checks = 0, pulses = 0;
  srlc_top #(.FRAME_DIV(4), .FILL_DWELL(2)) dut (.core_clk, .srst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .primary_fsm_reset_n,
    .lock_hold_reset_n, .wide_word_select, .test_clock_select, .test_clock_in,
    .link_active_in, .rx_word, .rx_data_valid_n, .rx_control_valid_n,
    .rx_error, .rx_fill_is_one, .fsm_state_bit0, .fsm_state_bit1,
    .recovered_frame_clock, .freq_detect_disable, .pll_restart, .link_ready_n,
    .data_out, .data_valid_n, .control_valid_n, .frame_error, .fill_frame_status, .irq);
  srlc_tx_model #(.LOCK_DLY(6)) txm (.core_clk, .lock_en, .fsm_state_bit1,
    .tx_locked(lock_hold_reset_n), .link_active(link_active_in));
  always #12.5 core_clk = ~core_clk;
  task automatic chk(string what, logic [32:0] exp, logic [32:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d, logic [32:0] exp);
    int n;
    n = 0;
    if (!wr) rdq.push_back(exp);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge core_clk);
    end
    chk("pready", 33'h1, {32'h0, pready});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic up(logic sw);
    int n;
    n = 0;
    stq.push_back(2'd1);
    stq.push_back(2'd2);
    stq.push_back(2'd3);
    primary_fsm_reset_n <= 1'b1;
    lock_en <= 1'b1;
    if (sw) apb(1'b1, OFS_CTRL, 32'h0, 33'h0);
    while ({fsm_state_bit1, fsm_state_bit0} !== 2'd3 && n < 400) begin
      n++;
      @(posedge core_clk);
    end
    chk("start-up", 33'h3, {31'h0, fsm_state_bit1, fsm_state_bit0});
    chk("restart off", 33'h0, {32'h0, pll_restart});
    $display("test start-up done");
  endtask : up
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  always @(posedge core_clk) begin
    if (recovered_frame_clock === 1'b1) pulses <= pulses + 1;
    if (psel && penable && pready && !pwrite) chk("read", rdq.pop_front(), {pslverr, prdata});
    if (!srst && {fsm_state_bit1, fsm_state_bit0} !== ps) begin
      ps <= {fsm_state_bit1, fsm_state_bit0};
      chk("state", stq.size() ? {31'h0, stq.pop_front()} : 33'h1_0000_0000,
          {31'h0, fsm_state_bit1, fsm_state_bit0});
    end
  end
  initial begin
    #2000000;
    errors++;
    finish_test();
  end
  initial begin
    int p0;
    logic [19:0] exp_w;
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    apb(1'b0, OFS_CTRL, 32'h0, 33'h0);
    apb(1'b0, 12'h100, 32'h0, 33'h1_0000_0000);
    apb(1'b1, OFS_IRQ_EN, 32'h1, 33'h0);
    repeat (40) @(posedge core_clk);
    up(1'b0);
    repeat (20) @(posedge core_clk);
    chk("irq", 33'h1, {32'h0, irq});
    apb(1'b0, OFS_STATUS, 32'h0, 33'h2F);
    apb(1'b0, OFS_IRQ_STAT, 32'h0, 33'h1);
    apb(1'b1, OFS_IRQ_CLR, 32'h1, 33'h0);
    apb(1'b0, OFS_IRQ_STAT, 32'h0, 33'h0);
    chk("irq clear", 33'h0, {32'h0, irq});
    p0 = pulses;
    repeat (40) @(posedge core_clk);
    chk("frames", 33'd10, 33'(pulses - p0));
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      rx_word <= seed[19:0];
      wide_word_select <= i[1];
      rx_data_valid_n <= i[0];
      rx_fill_is_one <= i[2];
      rx_control_valid_n <= (i != 5);
      repeat (16) @(posedge core_clk);
      exp_w = i[1] ? seed[19:0] : {4'h0, seed[15:0]};
      if (!i[0]) chk("word", {13'h0, exp_w}, {13'h0, data_out});
      chk("valid", {32'h0, i[0]}, {32'h0, data_valid_n});
      chk("control", {32'h0, (i != 5)}, {32'h0, control_valid_n});
      if (i[0]) chk("fill", {32'h0, (i[2] && i != 5)}, {32'h0, fill_frame_status});
    end
    rx_error <= 1'b1;
    apb(1'b1, OFS_IRQ_EN, 32'h5, 33'h0);
    repeat (16) @(posedge core_clk);
    chk("error", 33'h1, {32'h0, frame_error});
    chk("error fill", 33'h0, {32'h0, fill_frame_status});
    chk("irq error", 33'h1, {32'h0, irq});
    rx_error <= 1'b0;
    repeat (16) @(posedge core_clk);
    apb(1'b0, OFS_IRQ_STAT, 32'h0, 33'h4);
    apb(1'b1, OFS_IRQ_CLR, 32'h4, 33'h0);
    apb(1'b0, OFS_IRQ_STAT, 32'h0, 33'h0);
    wide_word_select <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h3, 33'h0);
    apb(1'b0, OFS_STATUS, 32'h0, 33'h3F);
    apb(1'b1, OFS_CTRL, 32'h0, 33'h0);
    $display("test error and forced modes done");
    wide_word_select <= 1'b1;
    test_clock_select <= 1'b1;
    repeat (8) @(posedge core_clk);
    p0 = pulses;
    repeat (40) @(posedge core_clk);
    repeat (3) begin
      test_clock_in <= 1'b1;
      repeat (4) @(posedge core_clk);
      test_clock_in <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    chk("test frames", 33'd3, 33'(pulses - p0));
    test_clock_select <= 1'b0;
    $display("test data and clocks done");
    stq.push_back(2'd0);
    primary_fsm_reset_n <= 1'b0;
    repeat (12) @(posedge core_clk);
    chk("restart", 33'h1, {32'h0, pll_restart});
    chk("irq masked", 33'h0, {32'h0, irq});
    up(1'b0);
    stq.push_back(2'd0);
    lock_en <= 1'b0;
    repeat (40) @(posedge core_clk);
    up(1'b0);
    stq.push_back(2'd0);
    apb(1'b1, OFS_CTRL, 32'h4, 33'h0);
    repeat (12) @(posedge core_clk);
    up(1'b1);
    @(posedge core_clk);
    chk("state queue", 33'h0, 33'(stq.size()));
    finish_test();
  end
endmodule : srlc_top_bench
bind srlc_top srlc_checker chk_i (.core_clk, .srst, .primary_fsm_reset_n,
  .lock_hold_reset_n, .fsm_state_bit0, .fsm_state_bit1, .freq_detect_disable,
  .pll_restart, .recovered_frame_clock, .link_ready_n, .data_out, .fill_frame_status);
`default_nettype wire
